// File: src/acr_defines.svh
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// ---------------------------------------------------------------
// Offsets and reset values
// ---------------------------------------------------------------
`define ACR_OFS_PAGE 8'h00
`define ACR_OFS_SWRST 8'h01
`define ACR_OFS_PWR 8'h02
`define ACR_OFS_PB 8'h03
`define ACR_PAGE_ZERO 8'h00
`define ACR_RST_PAGE 8'h00
`define ACR_RST_PWR 8'h0e
`define ACR_RST_PB 8'h20

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ACR_SWRST_BIT 0
`define ACR_PWR_PDM_BIT 7
`define ACR_PWR_LDO_BIT 6
`define ACR_PWR_RSV_HI 5
`define ACR_PWR_RSV_LO 4
`define ACR_PWR_ISNS_BIT 3
`define ACR_PWR_VSNS_BIT 2
`define ACR_PWR_MODE_HI 1
`define ACR_PWR_MODE_LO 0
`define ACR_PB_RO_BIT 7
`define ACR_PB_DCB_BIT 6
`define ACR_PB_LVL_HI 5
`define ACR_PB_LVL_LO 1
`define ACR_PB_RSV_BIT 0
`define ACR_LVL_MIN 5'h01
`define ACR_LVL_MAX 5'h1c

`endif

// File: src/acr_pkg.sv
package acr_pkg;
   typedef enum logic [1:0] {
      ACR_MODE_ACTIVE = 2'b00,
      ACR_MODE_MUTE = 2'b01,
      ACR_MODE_SHUTDOWN = 2'b10,
      ACR_MODE_DIAG = 2'b11
   } acr_mode_t;

   typedef enum logic [2:0] {
      ACR_ST_SHUTDOWN = 3'b000,
      ACR_ST_MUTE = 3'b001,
      ACR_ST_ACTIVE = 3'b010,
      ACR_ST_DIAG = 3'b011,
      ACR_ST_DIAG_ONLY = 3'b100
   } acr_state_t;
endpackage

// File: src/acr_mode_seq.sv
`include "acr_defines.svh"

module acr_mode_seq (
   input wire logic clk,
   input wire logic reset,
   input acr_pkg::acr_mode_t mode,
   input wire logic diag_only_req,
   input wire logic diag_done,
   output logic diag_only_ack,
   output acr_pkg::acr_state_t state
);
   import acr_pkg::*;

   acr_state_t state_r;
   acr_state_t state_nxt;
   logic diag_seen_r;
   logic in_diag;

   assign state = state_r;
   assign in_diag = (state_r == ACR_ST_DIAG) || (state_r == ACR_ST_DIAG_ONLY);
   // A diagnostics-only request waits for any running diagnostics
   assign diag_only_ack = diag_only_req && !in_diag;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ACR_ST_DIAG, ACR_ST_DIAG_ONLY: begin
            if (diag_done) begin
               state_nxt = ACR_ST_SHUTDOWN;
               if (state_r == ACR_ST_DIAG) begin
                  state_nxt = ACR_ST_ACTIVE;
               end
            end
         end
         ACR_ST_SHUTDOWN, ACR_ST_MUTE, ACR_ST_ACTIVE: begin
            if (diag_only_req) begin
               state_nxt = ACR_ST_DIAG_ONLY;
            end else begin
               unique case (mode)
                  ACR_MODE_ACTIVE: state_nxt = ACR_ST_ACTIVE;
                  ACR_MODE_MUTE: state_nxt = ACR_ST_MUTE;
                  ACR_MODE_SHUTDOWN: state_nxt = ACR_ST_SHUTDOWN;
                  ACR_MODE_DIAG: begin
                     state_nxt = diag_seen_r ? ACR_ST_ACTIVE : ACR_ST_DIAG;
                  end
               endcase
            end
         end
         default: state_nxt = ACR_ST_SHUTDOWN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= ACR_ST_SHUTDOWN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Diagnostics run once per entry into mode 11b, not in a loop
   always_ff @(posedge clk) begin
      if (reset || mode != ACR_MODE_DIAG) begin
         diag_seen_r <= 1'b0;
      end else if (state_r == ACR_ST_DIAG && diag_done) begin
         diag_seen_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   mode_active_a: assert property (
      (mode == ACR_MODE_ACTIVE && !diag_only_req && !in_diag)
      |=> state_r == ACR_ST_ACTIVE)
      else $error("Mode 00b did not reach active");
   mode_shutdown_a: assert property (
      (mode == ACR_MODE_SHUTDOWN && !diag_only_req && !in_diag)
      |=> state_r == ACR_ST_SHUTDOWN)
      else $error("Mode 10b did not reach shutdown");
   diag_then_active_a: assert property (
      (state_r == ACR_ST_DIAG && diag_done) |=> state_r == ACR_ST_ACTIVE)
      else $error("Diagnostics did not end in active");
   diag_cov_c: cover property (
      state_r == ACR_ST_DIAG ##1 state_r == ACR_ST_ACTIVE);
endmodule

// File: src/acr_register_bank.sv
`include "acr_defines.svh"

module acr_register_bank (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic diag_done,
   output logic [7:0] page_sel,
   output acr_pkg::acr_state_t amp_state,
   output logic diag_run,
   output logic isense_pd,
   output logic vsense_pd,
   output logic pdm_serial_en,
   output logic dc_block_bypass,
   output logic [4:0] amp_level,
   output logic amp_level_valid,
   output logic soft_reset_pulse
);
   import acr_pkg::*;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   // The page selector answers on every page; the rest only on page 0
   function automatic logic hit(input logic [7:0] addr,
                                input logic [7:0] page,
                                input logic [7:0] ofs);
      hit = (addr == ofs) &&
            (ofs == `ACR_OFS_PAGE || page == `ACR_PAGE_ZERO);
   endfunction

   logic [7:0] page_r;
   logic soft_reset_r;
   logic [7:0] pwr_r;
   logic load_diag_only_r;
   logic [7:0] pb_r;
   logic [7:0] reg_rdata_r;
   logic reg_rvalid_r;
   logic [7:0] rdata_nxt;
   logic hit_page;
   logic hit_swrst;
   logic hit_pwr;
   logic hit_pb;
   logic regs_clear;
   logic diag_only_ack;
   acr_state_t seq_state;

   assign hit_page = hit(reg_addr, page_r, `ACR_OFS_PAGE);
   assign hit_swrst = hit(reg_addr, page_r, `ACR_OFS_SWRST);
   assign hit_pwr = hit(reg_addr, page_r, `ACR_OFS_PWR);
   assign hit_pb = hit(reg_addr, page_r, `ACR_OFS_PB);
   // Power-on and soft reset share one path so defaults cannot drift
   assign regs_clear = reset || soft_reset_r;

   // ---------------------------------------------------------------
   // Page selector
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         page_r <= `ACR_RST_PAGE;
      end else if (reg_wr && hit_page) begin
         page_r <= reg_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Soft reset
   // ---------------------------------------------------------------
   // Held for one cycle, in which every register returns to default
   always_ff @(posedge clk) begin
      if (reset) begin
         soft_reset_r <= 1'b0;
      end else if (soft_reset_r) begin
         // A second write in the reset cycle is lost like any other
         soft_reset_r <= 1'b0;
      end else if (reg_wr && hit_swrst && reg_wdata[`ACR_SWRST_BIT]) begin
         soft_reset_r <= 1'b1;
      end else begin
         soft_reset_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Power control
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         pwr_r <= `ACR_RST_PWR;
      end else if (reg_wr && hit_pwr) begin
         // Bit 6 lives in its own self-clearing flop
         pwr_r <= reg_wdata & ~(8'h01 << `ACR_PWR_LDO_BIT);
      end
   end

   // A new request in the acknowledging cycle wins over the clear
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         load_diag_only_r <= 1'b0;
      end else if (reg_wr && hit_pwr && reg_wdata[`ACR_PWR_LDO_BIT]) begin
         load_diag_only_r <= 1'b1;
      end else if (diag_only_ack) begin
         load_diag_only_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Playback configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (regs_clear) begin
         pb_r <= `ACR_RST_PB;
      end else if (reg_wr && hit_pb) begin
         pb_r <= reg_wdata & ~(8'h01 << `ACR_PB_RO_BIT);
      end
   end

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   always_comb begin
      rdata_nxt = 8'h00;
      if (hit_page) begin
         rdata_nxt = page_r;
      end else if (hit_swrst) begin
         // Upper bits are read-only zero
         rdata_nxt = {7'h00, soft_reset_r};
      end else if (hit_pwr) begin
         rdata_nxt = pwr_r;
         rdata_nxt[`ACR_PWR_LDO_BIT] = load_diag_only_r;
      end else if (hit_pb) begin
         rdata_nxt = pb_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rvalid_r <= 1'b0;
      end else begin
         reg_rvalid_r <= reg_rd;
      end
   end

   // ---------------------------------------------------------------
   // Operating mode
   // ---------------------------------------------------------------
   acr_mode_seq u_mode_seq (
      .clk(clk),
      .reset(regs_clear),
      .mode(acr_mode_t'(pwr_r[`ACR_PWR_MODE_HI:`ACR_PWR_MODE_LO])),
      .diag_only_req(load_diag_only_r),
      .diag_done(diag_done),
      .diag_only_ack(diag_only_ack),
      .state(seq_state)
   );

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign reg_rdata = reg_rdata_r;
   assign reg_rvalid = reg_rvalid_r;
   assign page_sel = page_r;
   assign amp_state = seq_state;
   assign diag_run = (seq_state == ACR_ST_DIAG) ||
                     (seq_state == ACR_ST_DIAG_ONLY);
   assign isense_pd = pwr_r[`ACR_PWR_ISNS_BIT];
   assign vsense_pd = pwr_r[`ACR_PWR_VSNS_BIT];
   assign pdm_serial_en = pwr_r[`ACR_PWR_PDM_BIT];
   assign dc_block_bypass = pb_r[`ACR_PB_DCB_BIT];
   assign amp_level = pb_r[`ACR_PB_LVL_HI:`ACR_PB_LVL_LO];
   // Reserved codes are flagged, not clamped: the host owns the choice
   assign amp_level_valid = (amp_level >= `ACR_LVL_MIN) &&
                            (amp_level <= `ACR_LVL_MAX);
   assign soft_reset_pulse = soft_reset_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic wr_page_other;
   assign wr_page_other = reg_wr && hit_page && !soft_reset_r;

   page_write_a: assert property (
      wr_page_other |=> page_sel == $past(reg_wdata))
      else $error("Page selector did not take the written value");
   soft_defaults_a: assert property (
      soft_reset_r |=> (page_r == `ACR_RST_PAGE && pwr_r == `ACR_RST_PWR
                        && pb_r == `ACR_RST_PB && !load_diag_only_r))
      else $error("Soft reset left a register off its default");
   soft_clear_a: assert property (
      (reg_wr && hit_swrst && reg_wdata[`ACR_SWRST_BIT] && !soft_reset_r)
      |=> soft_reset_r ##1 !soft_reset_r)
      else $error("Soft reset bit did not clear itself");
   soft_zero_a: assert property (
      (!soft_reset_r && !(reg_wr && hit_swrst && reg_wdata[`ACR_SWRST_BIT]))
      |=> !soft_reset_r)
      else $error("Soft reset rose without a write of one");
   pwr_fields_a: assert property (
      (reg_wr && hit_pwr && !soft_reset_r) |=>
      (isense_pd == $past(reg_wdata[`ACR_PWR_ISNS_BIT]) &&
       vsense_pd == $past(reg_wdata[`ACR_PWR_VSNS_BIT]) &&
       pdm_serial_en == $past(reg_wdata[`ACR_PWR_PDM_BIT])))
      else $error("Power control fields did not follow the write");
   diag_only_clear_a: assert property (
      (load_diag_only_r && !diag_run && !soft_reset_r &&
       !(reg_wr && hit_pwr)) |=> (!load_diag_only_r &&
       amp_state == ACR_ST_DIAG_ONLY))
      else $error("Diagnostics-only bit did not start and clear");
   pb_fields_a: assert property (
      (reg_wr && hit_pb && !soft_reset_r) |=>
      (dc_block_bypass == $past(reg_wdata[`ACR_PB_DCB_BIT]) &&
       amp_level == $past(reg_wdata[`ACR_PB_LVL_HI:`ACR_PB_LVL_LO])))
      else $error("Playback fields did not follow the write");
   reserved_read_a: assert property (
      (reg_rd && hit_swrst) |=> (reg_rvalid && reg_rdata[7:1] == 7'h00))
      else $error("Read-only reserved bit read back nonzero");
   pb_reserved_a: assert property (
      (reg_rd && hit_pb) |=> (reg_rvalid && !reg_rdata[`ACR_PB_RO_BIT]))
      else $error("Playback read-only bit read back nonzero");
   soft_once_a: assert property (
      soft_reset_r |=> !soft_reset_r)
      else $error("Soft reset stood longer than one cycle");

   // ---------------------------------------------------------------
   // Register bus checks
   // ---------------------------------------------------------------
   rd_answer_a: assert property (
      reg_rd |=> reg_rvalid)
      else $error("Read got no answer in the next cycle");
   rd_pulse_a: assert property (
      !reg_rd |=> !reg_rvalid)
      else $error("Read answer stood longer than one cycle");
   rd_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("Read data changed without a read");
   // Off page 0 only the page selector answers
   other_page_rd_a: assert property (
      (reg_rd && !hit_page && page_r != `ACR_PAGE_ZERO)
      |=> reg_rdata == 8'h00)
      else $error("A register answered off page 0");
   other_page_wr_a: assert property (
      (reg_wr && page_r != `ACR_PAGE_ZERO && !soft_reset_r)
      |=> (pwr_r == $past(pwr_r) && pb_r == $past(pb_r)))
      else $error("A write off page 0 changed a register");

   // ---------------------------------------------------------------
   // Field checks
   // ---------------------------------------------------------------
   pwr_reserved_a: assert property (
      (reg_wr && hit_pwr && !soft_reset_r) |=>
      pwr_r[`ACR_PWR_RSV_HI:`ACR_PWR_RSV_LO] ==
      $past(reg_wdata[`ACR_PWR_RSV_HI:`ACR_PWR_RSV_LO]))
      else $error("Reserved power control bits did not store");
   pb_spare_a: assert property (
      (reg_wr && hit_pb && !soft_reset_r) |=>
      pb_r[`ACR_PB_RSV_BIT] == $past(reg_wdata[`ACR_PB_RSV_BIT]))
      else $error("Reserved playback bit did not store");
   pb_ro_zero_a: assert property (
      !pb_r[`ACR_PB_RO_BIT])
      else $error("Read-only playback bit was written");

   // ---------------------------------------------------------------
   // Sequencer checks
   // ---------------------------------------------------------------
   logic [1:0] mode_field;
   assign mode_field = pwr_r[`ACR_PWR_MODE_HI:`ACR_PWR_MODE_LO];

   mode_mute_a: assert property (
      (mode_field == ACR_MODE_MUTE && !load_diag_only_r && !diag_run &&
       !soft_reset_r) |=> amp_state == ACR_ST_MUTE)
      else $error("Mode 01b did not reach mute");
   diag_hold_a: assert property (
      (diag_run && !diag_done && !soft_reset_r)
      |=> amp_state == $past(amp_state))
      else $error("Diagnostics ended without completion");
   diag_only_end_a: assert property (
      (amp_state == ACR_ST_DIAG_ONLY && diag_done && !soft_reset_r)
      |=> amp_state == ACR_ST_SHUTDOWN)
      else $error("Diagnostics-only run did not end in shutdown");
   // A request during a run waits rather than being dropped
   diag_pending_a: assert property (
      (load_diag_only_r && diag_run && !soft_reset_r) |=> load_diag_only_r)
      else $error("Diagnostics-only request lost during a run");

   soft_reset_c: cover property (soft_reset_r ##1 !soft_reset_r);
   diag_pending_c: cover property (load_diag_only_r && diag_run);
   diag_only_c: cover property (amp_state == ACR_ST_DIAG_ONLY ##[1:20]
                                amp_state == ACR_ST_SHUTDOWN);
   other_page_c: cover property (page_r != `ACR_PAGE_ZERO && reg_rd);
endmodule

// File: bench/acr_diag_model.sv
// ---------------------------------------------------------------
// Diagnostics block stand-in: ends each run after a delay
// ---------------------------------------------------------------
module acr_diag_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic diag_run,
   input wire logic slow,
   output logic diag_done
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   logic fired;

   initial begin
      diag_done = 1'b0;
      cnt = 0;
      fired = 1'b0;
   end

   // One pulse per run only, so a run never sees a stale completion
   always @(negedge clk) begin
      diag_done <= 1'b0;
      if (reset || !diag_run) begin
         cnt <= 0;
         fired <= 1'b0;
      end else if (!fired) begin
         if (cnt >= (slow ? 6 : 0)) begin
            diag_done <= 1'b1;
            fired <= 1'b1;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule

// File: bench/acr_register_bank_tb.sv
module acr_register_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acr_pkg::*;
   logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, page_sel;
   logic reg_rvalid, diag_done, diag_run, isense_pd, vsense_pd, slow = 1'b0;
   logic pdm_serial_en, dc_block_bypass, amp_level_valid, soft_reset_pulse;
   logic [4:0] amp_level;
   acr_state_t amp_state;
   int errors = 0, checked = 0, cycles = 0;

   always #5 clk = ~clk;

   acr_register_bank dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .diag_done(diag_done),
      .page_sel(page_sel), .amp_state(amp_state), .diag_run(diag_run),
      .isense_pd(isense_pd), .vsense_pd(vsense_pd),
      .pdm_serial_en(pdm_serial_en), .dc_block_bypass(dc_block_bypass),
      .amp_level(amp_level), .amp_level_valid(amp_level_valid),
      .soft_reset_pulse(soft_reset_pulse));

   acr_diag_model diag (.clk(clk), .reset(reset), .diag_run(diag_run),
      .slow(slow), .diag_done(diag_done));

   // ---------------------------------------------------------------
   // Shared helpers
   // ---------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid}, 8'h01);
      chk(reg_rdata, exp);
   endtask

   // Bounded wait on the sequencer; a hang shows up as a mismatch
   task automatic wait_state(input acr_state_t s);
      for (int i = 0; i < 30 && amp_state !== s; i++)
         @(negedge clk);
      chk({5'h00, amp_state}, {5'h00, s});
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_defaults();
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h0e);
      rd(8'h03, 8'h20);
      chk({6'h00, isense_pd, vsense_pd}, 8'h03);
      chk({6'h00, pdm_serial_en, dc_block_bypass}, 8'h00);
      chk({3'h0, amp_level}, 8'h10);
      chk({5'h00, amp_state}, {5'h00, ACR_ST_SHUTDOWN});
   endtask

   task automatic t_paging();
      wr(8'h00, 8'hff);
      chk(page_sel, 8'hff);
      rd(8'h00, 8'hff);
      wr(8'h02, 8'h00);
      rd(8'h02, 8'h00);
      wr(8'h00, 8'h00);
      rd(8'h02, 8'h0e);
      wr(8'h00, 8'h01);
      chk(page_sel, 8'h01);
      wr(8'h00, 8'h00);
   endtask

   task automatic t_playback();
      logic [7:0] vals[5] = '{8'h02, 8'h38, 8'h3a, 8'h00, 8'h20};
      logic [4:0] lvl;
      wr(8'h03, 8'hff);
      rd(8'h03, 8'h7f);
      chk({7'h00, dc_block_bypass}, 8'h01);
      chk({7'h00, amp_level_valid}, 8'h00);
      foreach (vals[i]) begin
         wr(8'h03, vals[i]);
         lvl = vals[i][5:1];
         chk({7'h00, dc_block_bypass}, 8'h00);
         chk({3'h0, amp_level}, {3'h0, lvl});
         chk({7'h00, amp_level_valid},
             {7'h00, (lvl >= 5'h01 && lvl <= 5'h1c)});
      end
   endtask

   task automatic t_power();
      acr_state_t st[3] = '{ACR_ST_ACTIVE, ACR_ST_MUTE, ACR_ST_SHUTDOWN};
      wr(8'h02, 8'hb0);
      chk({5'h00, pdm_serial_en, isense_pd, vsense_pd}, 8'h04);
      rd(8'h02, 8'hb0);
      wr(8'h02, 8'h0c);
      chk({6'h00, isense_pd, vsense_pd}, 8'h03);
      chk({7'h00, pdm_serial_en}, 8'h00);
      for (int m = 0; m < 3; m++) begin
         wr(8'h02, 8'(m));
         @(negedge clk);
         chk({5'h00, amp_state}, {5'h00, st[m]});
      end
   endtask

   task automatic t_diag_mode();
      slow = 1'b1;
      wr(8'h02, 8'h03);
      @(negedge clk);
      chk({5'h00, amp_state}, {5'h00, ACR_ST_DIAG});
      chk({7'h00, diag_run}, 8'h01);
      // A diagnostics-only request during the run stays pending
      wr(8'h02, 8'h43);
      rd(8'h02, 8'h43);
      wait_state(ACR_ST_ACTIVE);
      wait_state(ACR_ST_DIAG_ONLY);
      wait_state(ACR_ST_ACTIVE);
      repeat (3) @(negedge clk);
      chk({7'h00, diag_run}, 8'h00);
      slow = 1'b0;
   endtask

   task automatic t_soft_reset();
      wr(8'h03, 8'h7e);
      wr(8'h01, 8'h01);
      chk({7'h00, soft_reset_pulse}, 8'h01);
      @(negedge clk);
      chk({7'h00, soft_reset_pulse}, 8'h00);
      chk({3'h0, amp_level}, 8'h10);
      chk({5'h00, amp_state}, {5'h00, ACR_ST_SHUTDOWN});
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h0e);
      rd(8'h03, 8'h20);
   endtask

   task automatic t_diag_only();
      wr(8'h02, 8'h4e);
      @(negedge clk);
      chk({5'h00, amp_state}, {5'h00, ACR_ST_DIAG_ONLY});
      rd(8'h02, 8'h0e);
      wait_state(ACR_ST_SHUTDOWN);
      chk({7'h00, diag_run}, 8'h00);
   endtask

   task automatic t_reset_zero();
      wr(8'h03, 8'h44);
      wr(8'h01, 8'h00);
      chk({7'h00, soft_reset_pulse}, 8'h00);
      @(negedge clk);
      rd(8'h03, 8'h44);
   endtask

   // ---------------------------------------------------------------
   // Main sequence and hang guard
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         test_done();
      end
   end

   initial begin
      repeat (2) @(negedge clk);
      reset = 1'b0;
      t_defaults();
      t_paging();
      t_playback();
      t_power();
      t_diag_mode();
      t_soft_reset();
      t_diag_only();
      t_reset_zero();
      test_done();
   end
endmodule
